// ### uss_pkg.sv
// Constants shared by the serial command port and its transceiver
package uss_pkg;
  // Command opcodes in the upper five bits
  localparam logic [4:0] OP_RD_BUF = 5'h00;
  localparam logic [4:0] OP_WR_BUF = 5'h01;
  localparam logic [4:0] OP_RD_REG = 5'h02;
  localparam logic [4:0] OP_WR_REG = 5'h03;
  // Register addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CTRL2 = 3'h2;
  localparam logic [2:0] ADDR_BAUD = 3'h3;
  localparam logic [2:0] ADDR_CTRL3 = 3'h4;
  // Frame shape
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  // Status bit positions
  localparam int ST_FERR = 5;
  localparam int ST_OERR = 4;
  localparam int ST_RIDLE = 3;
  localparam int ST_RAVAIL = 2;
  localparam int ST_TIDLE = 1;
  localparam int ST_TEMPTY = 0;
  // Control 1 positions
  localparam int C1_EN = 7;
  localparam int C1_NINE = 6;
  localparam int C1_RX9 = 1;
  localparam int C1_TX9 = 0;
  // Control 2 positions
  localparam int C2_TXEN = 7;
  localparam int C2_RXEN = 6;
  localparam int C2_RXIE = 2;
  localparam int C2_TIDLEIE = 1;
  localparam int C2_TEMPTYIE = 0;
  // Control 3 position
  localparam int C3_SRST = 7;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] CTRL3_RST = 8'h00;
  // Transceiver frame lengths: transmit counts start and stop, receive counts stop but not start
  localparam logic [3:0] TX_LEN8 = 4'ha;
  localparam logic [3:0] TX_LEN9 = 4'hb;
  localparam logic [3:0] RX_LEN8 = 4'h9;
  localparam logic [3:0] RX_LEN9 = 4'ha;
  // Interrupt pulse timing
  localparam int REF_PERIOD_NS = 40;
  localparam int IRQ_PULSE_NS = 200;
  localparam logic [3:0] IRQ_PULSE_CYC = 4'((IRQ_PULSE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
  // Receiver states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } uss_rx_type;
endpackage

// ### uss_top.sv
// Serial command port slave with embedded asynchronous transceiver
`timescale 1ns/1ps
`default_nettype none
module uss_top #(
  parameter int BIT_SCALE = 16
) (
  input wire logic REF_CLK, // Module clock, 25 MHz
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic SPI_SCK, // Serial clock from master
  input wire logic SPI_CS_N, // Chip select, active low
  input wire logic SPI_SDI, // Serial data in
  output logic SPI_SDO, // Serial data out
  output logic SPI_SDO_OE, // Serial out enable
  input wire logic UART_RX, // Transceiver receive line
  output logic UART_TX, // Transceiver transmit line
  output logic UART_TX_OE, // Transmit line enable
  output logic MODULE_IRQ_N // Interrupt, low pulse
);
  import uss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset toward the serial clock domain
  logic link_rst_q;
  always_ff @(posedge REF_CLK) begin
    link_rst_q <= ~RST_N;
  end
  // Frame ends by its own select; serial clock stops outside frames
  logic frame_clr;
  assign frame_clr = SPI_CS_N | link_rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] frame_q;
  logic done_tgl_q;
  logic [7:0] out_q;
  logic [7:0] snap_q [0:7];
  logic [7:0] snap_rx_q;

  always_ff @(posedge SPI_SCK or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != FRAME_BITS) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge SPI_SCK) begin
    if (bit_cnt_q != FRAME_BITS) begin
      shift_q <= {shift_q[14:0], SPI_SDI};
    end
  end

  // Completed frames only; a partial frame never flips the toggle
  always_ff @(posedge SPI_SCK or posedge link_rst_q) begin
    if (link_rst_q) begin
      done_tgl_q <= 1'b0;
    end else if (bit_cnt_q == LAST_BIT) begin
      done_tgl_q <= ~done_tgl_q;
    end
  end

  always_ff @(posedge SPI_SCK) begin
    if (bit_cnt_q == LAST_BIT) begin
      frame_q <= {shift_q[14:0], SPI_SDI};
    end
  end

  function automatic logic [7:0] read_sel(input logic [7:0] cmd);
    logic [7:0] r;
    r = 8'h00;
    if (cmd[7:3] == OP_RD_BUF) begin
      r = snap_rx_q;
    end else if (cmd[7:3] == OP_RD_REG) begin
      r = snap_q[cmd[2:0]];
    end
    return r;
  endfunction

  // Snapshot is frozen during frames, so reading it here is safe
  always_ff @(negedge SPI_SCK or posedge frame_clr) begin
    if (frame_clr) begin
      out_q <= 8'h00;
    end else if (bit_cnt_q == CMD_BITS) begin
      out_q <= read_sel(shift_q[7:0]);
    end else begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign SPI_SDO = out_q[7];
  assign SPI_SDO_OE = ~SPI_CS_N;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the module clock
  logic cs_meta_q, cs_s_q, tgl_meta_q, tgl_s_q, rx_meta_q, rx_s_q, seen_q;
  always_ff @(posedge REF_CLK) begin
    cs_meta_q <= SPI_CS_N;
    cs_s_q <= cs_meta_q;
    tgl_meta_q <= done_tgl_q;
    tgl_s_q <= tgl_meta_q;
    rx_meta_q <= UART_RX;
    rx_s_q <= rx_meta_q;
  end

  logic exec;
  logic [7:0] cmd_w, dat_w;
  // Acts only once select is seen high again after a full frame
  assign exec = cs_s_q & (tgl_s_q != seen_q);
  assign cmd_w = frame_q[15:8];
  assign dat_w = frame_q[7:0];

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      seen_q <= 1'b0;
    end else if (exec) begin
      seen_q <= tgl_s_q;
    end
  end

  logic wr_reg, wr_buf, rd_buf;
  assign wr_reg = exec & (cmd_w[7:3] == OP_WR_REG);
  assign wr_buf = exec & (cmd_w[7:3] == OP_WR_BUF);
  assign rd_buf = exec & (cmd_w[7:3] == OP_RD_BUF);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] ctrl1_q, ctrl2_q, baud_q, ctrl3_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      baud_q <= BAUD_RST;
      ctrl3_q <= CTRL3_RST;
    end else if (wr_reg) begin
      case (cmd_w[2:0])
        ADDR_CTRL1: ctrl1_q <= dat_w;
        ADDR_CTRL2: ctrl2_q <= dat_w;
        ADDR_BAUD: baud_q <= dat_w;
        ADDR_CTRL3: ctrl3_q <= dat_w;
        default: ctrl1_q <= ctrl1_q;
      endcase
    end
  end

  logic nine, uart_on, uart_clr;
  assign nine = ctrl1_q[C1_NINE];
  assign uart_on = ctrl1_q[C1_EN] & ~ctrl3_q[C3_SRST];
  assign uart_clr = ~RST_N | ~uart_on;
  logic [15:0] bit_len;
  assign bit_len = 16'((16'(baud_q) + 16'h0001) * 16'(BIT_SCALE));

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  logic [8:0] tx_hold_q;
  logic tx_empty_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [15:0] tx_cnt_q;
  logic tx_load, tx_done;
  assign tx_load = (tx_left_q == 4'h0) & ~tx_empty_q & ctrl2_q[C2_TXEN];
  assign tx_done = (tx_left_q == 4'h1) & (tx_cnt_q == 16'h0000);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tx_hold_q <= 9'h000;
    end else if (wr_buf) begin
      tx_hold_q <= {ctrl1_q[C1_TX9], dat_w};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (uart_clr) begin
      tx_empty_q <= 1'b1;
    end else if (wr_buf) begin
      tx_empty_q <= 1'b0;
    end else if (tx_load) begin
      tx_empty_q <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (uart_clr) begin
      tx_sh_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
    end else if (tx_load) begin
      tx_sh_q <= {1'b1, nine ? tx_hold_q[8] : 1'b1, tx_hold_q[7:0], 1'b0};
      tx_left_q <= nine ? TX_LEN9 : TX_LEN8;
      tx_cnt_q <= bit_len - 16'h0001;
    end else if (tx_left_q != 4'h0) begin
      if (tx_cnt_q == 16'h0000) begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        tx_cnt_q <= bit_len - 16'h0001;
      end else begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end
    end
  end

  assign UART_TX = tx_sh_q[0];
  assign UART_TX_OE = uart_on & ctrl2_q[C2_TXEN];

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  uss_rx_type rx_state_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_left_q;
  logic [9:0] rx_sh_q, rx_new;
  logic rx_char, rx_stop;
  assign rx_new = {rx_s_q, rx_sh_q[9:1]};
  assign rx_char = (rx_state_q == RX_BITS) & (rx_cnt_q == 16'h0000) & (rx_left_q == 4'h1);
  assign rx_stop = rx_s_q;

  always_ff @(posedge REF_CLK) begin
    if (uart_clr) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_left_q <= 4'h0;
      rx_sh_q <= 10'h000;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (ctrl2_q[C2_RXEN] && !rx_s_q) begin
            rx_state_q <= RX_START;
            rx_cnt_q <= {1'b0, bit_len[15:1]};
          end
        end
        RX_START: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (!rx_s_q) begin
            rx_state_q <= RX_BITS;
            rx_cnt_q <= bit_len - 16'h0001;
            rx_left_q <= nine ? RX_LEN9 : RX_LEN8;
          end else begin
            rx_state_q <= RX_IDLE;
          end
        end
        RX_BITS: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_sh_q <= rx_new;
            rx_left_q <= rx_left_q - 4'h1;
            rx_cnt_q <= bit_len - 16'h0001;
            if (rx_left_q == 4'h1) begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  logic [7:0] rx_data_q;
  logic rx9_q, rx_avail_q, oerr_q, ferr_q;
  // Set wins over the clear that a buffer read brings
  always_ff @(posedge REF_CLK) begin
    if (uart_clr) begin
      rx_data_q <= 8'h00;
      rx9_q <= 1'b0;
      rx_avail_q <= 1'b0;
      oerr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      if (rx_char && !rx_avail_q) begin
        rx_data_q <= nine ? rx_new[7:0] : rx_new[8:1];
        rx9_q <= nine & rx_new[8];
        rx_avail_q <= 1'b1;
      end else if (rd_buf) begin
        rx_avail_q <= 1'b0;
      end
      if (rx_char && rx_avail_q) begin
        oerr_q <= 1'b1;
      end else if (rd_buf) begin
        oerr_q <= 1'b0;
      end
      if (rx_char && !rx_stop) begin
        ferr_q <= 1'b1;
      end else if (rd_buf) begin
        ferr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read snapshot, refreshed only while select is high
  logic [7:0] status_w;
  assign status_w = {2'b00, ferr_q, oerr_q, rx_state_q == RX_IDLE, rx_avail_q,
                     tx_empty_q & (tx_left_q == 4'h0), tx_empty_q};
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) begin
        snap_q[i] <= 8'h00;
      end
      snap_rx_q <= 8'h00;
    end else if (cs_s_q && !exec) begin
      snap_q[ADDR_STATUS] <= status_w;
      snap_q[ADDR_CTRL1] <= {ctrl1_q[7:2], rx9_q, ctrl1_q[C1_TX9]};
      snap_q[ADDR_CTRL2] <= ctrl2_q;
      snap_q[ADDR_BAUD] <= baud_q;
      snap_q[ADDR_CTRL3] <= ctrl3_q;
      snap_rx_q <= rx_data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulse
  logic irq_ev;
  logic [3:0] irq_cnt_q, irq_cnt_d;
  logic irq_n_q;
  assign irq_ev = (rx_char & ~rx_avail_q & ctrl2_q[C2_RXIE])
                | (tx_done & tx_empty_q & ctrl2_q[C2_TIDLEIE])
                | (tx_load & ctrl2_q[C2_TEMPTYIE]);
  always_comb begin
    irq_cnt_d = irq_cnt_q;
    if (irq_ev) begin
      irq_cnt_d = IRQ_PULSE_CYC;
    end else if (irq_cnt_q != 4'h0) begin
      irq_cnt_d = irq_cnt_q - 4'h1;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      irq_cnt_q <= 4'h0;
      irq_n_q <= 1'b1;
    end else begin
      irq_cnt_q <= irq_cnt_d;
      irq_n_q <= (irq_cnt_d == 4'h0);
    end
  end
  assign MODULE_IRQ_N = irq_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_OE_OFF_IDLE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(cs_s_q) |-> !SPI_SDO_OE) else $error("output enabled while deselected");
  AST_TGL_FULL: assert property (@(posedge SPI_SCK) disable iff (frame_clr)
    bit_cnt_q != LAST_BIT |=> $stable(done_tgl_q)) else $error("partial frame completed");
  AST_EXEC_DESEL: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_reg |-> cs_s_q ##1 !exec) else $error("write executed under select");
  AST_CNT_SAT: assert property (@(posedge SPI_SCK) disable iff (frame_clr)
    bit_cnt_q == FRAME_BITS |=> bit_cnt_q == FRAME_BITS) else $error("frame counter overran");
  AST_OERR: assert property (@(posedge REF_CLK) disable iff (uart_clr)
    rx_char && rx_avail_q && !rd_buf |=> oerr_q && rx_avail_q) else $error("overrun not flagged");
  AST_FERR: assert property (@(posedge REF_CLK) disable iff (uart_clr)
    rx_char && !rx_stop |=> ferr_q) else $error("framing error not flagged");
  AST_TX_LEN: assert property (@(posedge REF_CLK) disable iff (uart_clr)
    tx_load |=> tx_left_q == (nine ? 4'hb : 4'ha) && UART_TX == 1'b0) else $error("bad transmit frame");
  AST_IRQ_PULSE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    irq_ev |=> !MODULE_IRQ_N [*5]) else $error("interrupt pulse too short");
  AST_RX_IRQ: assert property (@(posedge REF_CLK) disable iff (uart_clr)
    rx_char && !rx_avail_q && ctrl2_q[C2_RXIE] |=> !MODULE_IRQ_N) else $error("receive interrupt missing");
  COV_WR_REG: cover property (@(posedge REF_CLK) wr_reg);
  COV_RD_BUF: cover property (@(posedge REF_CLK) rd_buf && rx_avail_q);
  COV_RX_CHAR: cover property (@(posedge REF_CLK) rx_char && rx_stop);
  COV_TX_DONE: cover property (@(posedge REF_CLK) tx_done);
endmodule // uss_top
`default_nettype wire

// ### uss_host_model.sv
// Host master model driving frames into the serial command port
`timescale 1ns/1ps
`default_nettype none
module uss_host_model (
  output logic sck, // Serial clock, idles high
  output logic cs_n, // Chip select, active low
  output logic sdi, // Data towards slave
  input wire logic sdo, // Data from slave
  input wire logic sdo_oe // Slave output enable
);
  // Half of the 15 ns link period
  localparam realtime HALF = 7.5;
  initial begin
    sck = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b1;
  end
  // Fewer than 16 bits makes an aborted frame
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, input int nbits,
                      output logic [7:0] rd, output logic oe_seen);
    logic [15:0] word;
    word = {cmd, dat};
    rd = 8'h00;
    oe_seen = 1'b1;
    cs_n <= 1'b0;
    #(8 * HALF);
    sck <= 1'b0;
    #(8 * HALF);
    for (int i = 0; i < nbits; i++) begin
      sdi <= word[15 - i];
      #HALF;
      if (i >= 8) begin
        rd = {rd[6:0], sdo};
      end
      oe_seen = oe_seen & sdo_oe;
      sck <= 1'b1;
      #HALF;
      if (i < nbits - 1) begin
        sck <= 1'b0;
      end
    end
    #HALF;
    cs_n <= 1'b1;
    // Released line shows no stale value
    sdi <= ~sdi;
    #480;
  endtask
endmodule // uss_host_model
`default_nettype wire

// ### uart_spi_slave_interface_tb.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module uart_spi_slave_interface_tb;
  import uss_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  wire logic SPI_SCK;
  wire logic SPI_CS_N;
  wire logic SPI_SDI;
  logic SPI_SDO;
  logic SPI_SDO_OE;
  wire logic UART_RX;
  logic UART_TX;
  logic UART_TX_OE;
  logic MODULE_IRQ_N;
  int n_fail = 0;
  int comparisons = 0;
  int run_len = 0;
  int pulse_len = 0;
  int n_pulse = 0;
  int cyc = 0;
  int tx_fall = -100;
  int tx_frames = 0;
  logic tx_prev = 1'b1;
  logic [10:0] tx_cap = 11'h7ff;
  logic [7:0] rd_v;
  logic oe_v;
  always #20 REF_CLK = ~REF_CLK;
  // Loopback; undriven line rests high as an idle serial line
  assign UART_RX = UART_TX_OE ? UART_TX : 1'b1;
  uss_top #(.BIT_SCALE(1)) uut (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .SPI_SDI(SPI_SDI),
    .SPI_SDO(SPI_SDO), .SPI_SDO_OE(SPI_SDO_OE), .UART_RX(UART_RX), .UART_TX(UART_TX),
    .UART_TX_OE(UART_TX_OE), .MODULE_IRQ_N(MODULE_IRQ_N)
  );
  uss_host_model host (
    .sck(SPI_SCK), .cs_n(SPI_CS_N), .sdi(SPI_SDI), .sdo(SPI_SDO), .sdo_oe(SPI_SDO_OE)
  );
  // Length of the last low pulse on the interrupt line
  always @(negedge REF_CLK) begin
    if (MODULE_IRQ_N === 1'b0) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      pulse_len <= run_len;
      run_len <= 0;
      n_pulse <= n_pulse + 1;
    end
  end
  // Captures each transmitted frame; bit time is (3+1)*1 cycles, sampled mid-bit
  always @(negedge REF_CLK) begin
    cyc <= cyc + 1;
    tx_prev <= UART_TX;
    if (cyc > tx_fall + 46 && tx_prev === 1'b1 && UART_TX === 1'b0) begin
      tx_fall <= cyc;
    end else if (cyc >= tx_fall + 2 && cyc <= tx_fall + 42 && (cyc - tx_fall - 2) % 4 == 0) begin
      tx_cap[(cyc - tx_fall - 2) / 4] <= UART_TX;
    end
    if (cyc == tx_fall + 42) begin
      tx_frames <= tx_frames + 1;
    end
  end
  task automatic wait_tx(input int f0);
    int k;
    k = 0;
    while (tx_frames == f0) begin
      k++;
      if (k > 300) begin
        n_fail++;
        conclude();
      end
      @(negedge REF_CLK);
    end
  endtask
  task automatic wait_irq(input int p0);
    int k;
    k = 0;
    while (n_pulse == p0) begin
      k++;
      if (k > 300) begin
        n_fail++;
        conclude();
      end
      @(negedge REF_CLK);
    end
  endtask
  task automatic chk_tx(input logic [8:0] d, input logic nine_on);
    `CHK(tx_cap[0], 1'b0)
    for (int i = 0; i < 8; i++) begin
      `CHK(tx_cap[i + 1], d[i])
    end
    if (nine_on) begin
      `CHK(tx_cap[9], d[8])
      `CHK(tx_cap[10], 1'b1)
    end else begin
      `CHK(tx_cap[9], 1'b1)
    end
  endtask
  task automatic conclude;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic frame(input logic [4:0] op, input logic [2:0] a, input logic [7:0] d, input int n);
    host.xfer({op, a}, d, n, rd_v, oe_v);
  endtask
  task automatic t_regs;
    `CHK(SPI_SDO_OE, 1'b0)
    `CHK(MODULE_IRQ_N, 1'b1)
    frame(OP_WR_REG, ADDR_BAUD, 8'h03, 16);
    frame(OP_RD_REG, ADDR_BAUD, 8'h00, 16);
    `CHK(rd_v, 8'h03)
    `CHK(oe_v, 1'b1)
    frame(OP_WR_REG, ADDR_CTRL2, 8'hc4, 16);
    frame(OP_RD_REG, ADDR_CTRL2, 8'h00, 16);
    `CHK(rd_v, 8'hc4)
    frame(OP_RD_REG, 3'h5, 8'h00, 16);
    `CHK(rd_v, 8'h00)
    $display("test regs done");
  endtask
  task automatic t_abort;
    frame(OP_WR_REG, ADDR_BAUD, 8'h55, 12);
    frame(OP_WR_REG, ADDR_BAUD, 8'h55, 8);
    frame(OP_RD_REG, ADDR_BAUD, 8'h00, 16);
    `CHK(rd_v, 8'h03)
    $display("test abort done");
  endtask
  task automatic t_uart;
    int f0, p0;
    logic [7:0] ch;
    ch = 8'ha5;
    frame(OP_WR_REG, ADDR_CTRL1, 8'h80, 16);
    `CHK(UART_TX_OE, 1'b1)
    f0 = tx_frames;
    p0 = n_pulse;
    frame(OP_WR_BUF, 3'h7, ch, 16);
    wait_tx(f0);
    chk_tx({1'b0, ch}, 1'b0);
    wait_irq(p0);
    `CHK(pulse_len, 32'(IRQ_PULSE_CYC))
    frame(OP_RD_REG, ADDR_STATUS, 8'h00, 16);
    `CHK(rd_v, 8'h0f)
    frame(OP_RD_BUF, 3'h2, 8'h00, 16);
    `CHK(rd_v, ch)
    frame(OP_RD_REG, ADDR_STATUS, 8'h00, 16);
    `CHK(rd_v, 8'h0b)
    $display("test uart done");
  endtask
  // Nine-bit frames, then a second character onto a full buffer
  task automatic t_nine;
    int f0, p0;
    frame(OP_WR_REG, ADDR_CTRL1, 8'hc1, 16);
    f0 = tx_frames;
    p0 = n_pulse;
    frame(OP_WR_BUF, 3'h0, 8'h3c, 16);
    wait_tx(f0);
    chk_tx(9'h13c, 1'b1);
    wait_irq(p0);
    `CHK(pulse_len, 32'(IRQ_PULSE_CYC))
    frame(OP_RD_REG, ADDR_CTRL1, 8'h00, 16);
    `CHK(rd_v, 8'hc3)
    f0 = tx_frames;
    frame(OP_WR_BUF, 3'h0, 8'h99, 16);
    wait_tx(f0);
    chk_tx(9'h199, 1'b1);
    repeat (20) @(negedge REF_CLK);
    frame(OP_RD_REG, ADDR_STATUS, 8'h00, 16);
    `CHK(rd_v, 8'h1f)
    frame(OP_RD_BUF, 3'h0, 8'h00, 16);
    `CHK(rd_v, 8'h3c)
    frame(OP_RD_REG, ADDR_STATUS, 8'h00, 16);
    `CHK(rd_v, 8'h0b)
    $display("test nine done");
  endtask
  initial begin
    repeat (8) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    #3;
    t_regs();
    t_abort();
    t_uart();
    t_nine();
    conclude();
  end
endmodule // uart_spi_slave_interface_tb
`default_nettype wire
